//--- common/addr_decoder_pkg.sv
package addr_decoder_pkg;

  // processor memory map, inclusive bounds
  localparam logic [15:0] CORE_REG_LO = 16'h0000;
  localparam logic [15:0] CORE_REG_HI = 16'h001f;
  localparam logic [15:0] PERIPH_LO = 16'h0020;
  localparam logic [15:0] PERIPH_HI = 16'h007f;
  localparam logic [15:0] RAM_LO = 16'h0080;
  localparam logic [15:0] RAM_HI = 16'h17ff;
  localparam logic [15:0] EXT_LOW_LO = 16'h1800;
  localparam logic [15:0] EXT_LOW_HI = 16'h7fff;
  localparam logic [15:0] BANKED_LO = 16'h8000;
  localparam logic [15:0] BANKED_HI = 16'hbfff;
  localparam logic [15:0] EXT_HIGH_LO = 16'hc000;
  localparam logic [15:0] EXT_HIGH_HI = 16'hfdff;
  localparam logic [15:0] ROM_LO = 16'hfe00;

  // address held on the bus while the processor sleeps
  localparam logic [15:0] SLEEP_ADDR = 16'hffff;

  // bank select register, placed in on-chip peripheral space
  localparam logic [15:0] BANK_SEL_ADDR = 16'h0030;
  localparam int BANK_CS_BIT = 4;
  localparam logic [4:0] BANK_SEL_RESET = 5'h00;

  // page logic
  localparam logic [1:0] BANKED_TOP = 2'h2;
  localparam logic [1:0] ROOT_PAGE_TOP = 2'h3;

  // reset values of the control bits
  localparam logic BOOT_ROM_SEL_RESET = 1'b1;
  localparam logic SLEEP_GATE_RESET = 1'b0;

  // pin synchroniser depth
  localparam int SYNC_STAGES = 2;

  typedef enum logic [5:0] {
    REGION_CORE = 6'h01,
    REGION_PERIPH = 6'h02,
    REGION_RAM = 6'h04,
    REGION_BOOT_ROM = 6'h08,
    REGION_EXT = 6'h10,
    REGION_BANKED = 6'h20
  } region_t;

endpackage : addr_decoder_pkg

//--- rtl/pin_sync.sv
module pin_sync #(
  parameter int WIDTH = 1,
  parameter int STAGES = addr_decoder_pkg::SYNC_STAGES
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // asynchronous pins in, synchronised levels out
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_sync_out
);

  logic [WIDTH-1:0] stage [STAGES];

  // first stage is read only by the next stage
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < STAGES; i++) begin
        stage[i] <= '0;
      end
    end else begin
      stage[0] <= pin_in;
      for (int i = 1; i < STAGES; i++) begin
        stage[i] <= stage[i-1];
      end
    end
  end

  assign pin_sync_out = stage[STAGES-1];

endmodule : pin_sync

//--- rtl/addr_decoder_bus_if.sv
// Functional notes
// - decode core regs, peripherals, RAM, external, banked, ROM windows
// - boot ROM select, set at reset, steers FE00-FFFF internal or external
// - with sleep gating on, no program select for address FFFF
// - active-low output enable on reads, write enable on writes
// - emulation pin high builds internal buses from external pins
// - low address byte follows data pins while address strobe high, held after it falls
// - read/write driven in normal mode, input in emulation
// - data pins bidirectional normally, inputs in emulation
// - low eight address pins always outputs
// - address pins 13:8 outputs normally, inputs in emulation
// - top address bits feed page logic only; pins used in emulation
// - four page outputs extend external address to 18 bits
// - after reset all external accesses use program select
// - bank register bit 4 picks chip select in banked area
// - emulation bus writes bank register; external access unchanged
// - bank register used by page logic only for top address bits equal to 10
// - outside bank: page top 11, next copy address 15:14, program select
// - in bank: page equals bank bits 3:0, bit 4 picks select
module addr_decoder_bus_if (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // embedded processor bus
  input wire logic [15:0] cpu_addr,
  input wire logic [7:0] cpu_wdata,
  input wire logic cpu_rnw,
  input wire logic cpu_valid,
  input wire logic cpu_data_phase,
  output logic [7:0] cpu_rdata,
  // control bits
  input wire logic boot_rom_wr,
  input wire logic boot_rom_wdata,
  output logic boot_rom_select,
  input wire logic sleep_gate_wr,
  input wire logic sleep_gate_wdata,
  output logic sleep_gate,
  output logic [4:0] bank_sel,
  // internal bus to on-chip functions
  output logic [15:0] bus_addr,
  output logic [7:0] bus_wdata,
  output logic bus_rnw,
  output logic bus_valid,
  output logic bus_data_phase,
  output logic [5:0] bus_region,
  // emulation pins
  input wire logic bypass_cpu_pin,
  input wire logic emu_addr_latch_strobe,
  input wire logic emu_data_phase,
  input wire logic [1:0] emu_addr_hi,
  // read/write pin
  input wire logic rnw_in,
  output logic rnw_out,
  output logic rnw_oe,
  // data pins
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe,
  // address pins
  output logic [7:0] addr_lo,
  input wire logic [5:0] addr_mid_in,
  output logic [5:0] addr_mid_out,
  output logic addr_mid_oe,
  output logic [3:0] page_addr,
  // memory strobes
  output logic out_enable_n,
  output logic write_enable_n,
  output logic program_mem_select_n,
  output logic second_mem_select_n
);

  localparam int PIN_W = 20;

  logic [PIN_W-1:0] pins_raw;
  logic [PIN_W-1:0] pins_s;
  logic emu;
  logic strobe_s;
  logic ephase_s;
  logic [1:0] hi_s;
  logic rnw_s;
  logic [7:0] data_s;
  logic [5:0] mid_s;
  logic [7:0] emu_addr_lo;
  logic [15:0] next_addr;
  logic [7:0] next_wdata;
  logic next_rnw;
  logic next_valid;
  logic next_phase;
  addr_decoder_pkg::region_t region;
  logic ext_acc;
  logic banked;
  logic sel_second;
  logic sel_program;

  function automatic addr_decoder_pkg::region_t decode(
    input logic [15:0] a,
    input logic rom_on
  );
    addr_decoder_pkg::region_t r;
    r = addr_decoder_pkg::REGION_EXT;
    if (a <= addr_decoder_pkg::CORE_REG_HI) begin
      r = addr_decoder_pkg::REGION_CORE;
    end else if (a <= addr_decoder_pkg::PERIPH_HI) begin
      r = addr_decoder_pkg::REGION_PERIPH;
    end else if (a <= addr_decoder_pkg::RAM_HI) begin
      r = addr_decoder_pkg::REGION_RAM;
    end else if (a <= addr_decoder_pkg::EXT_LOW_HI) begin
      r = addr_decoder_pkg::REGION_EXT;
    end else if (a <= addr_decoder_pkg::BANKED_HI) begin
      r = addr_decoder_pkg::REGION_BANKED;
    end else if (a <= addr_decoder_pkg::EXT_HIGH_HI) begin
      r = addr_decoder_pkg::REGION_EXT;
    end else if (rom_on) begin
      r = addr_decoder_pkg::REGION_BOOT_ROM;
    end else begin
      r = addr_decoder_pkg::REGION_EXT;
    end
    return r;
  endfunction : decode

  // every pin from the emulator crosses two flops first
  assign pins_raw = {bypass_cpu_pin, emu_addr_latch_strobe, emu_data_phase,
                     emu_addr_hi, rnw_in, data_in, addr_mid_in};

  pin_sync #(
    .WIDTH(PIN_W),
    .STAGES(addr_decoder_pkg::SYNC_STAGES)
  ) u_pin_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .pin_in(pins_raw),
    .pin_sync_out(pins_s)
  );

  assign emu = pins_s[19];
  assign strobe_s = pins_s[18];
  assign ephase_s = pins_s[17];
  assign hi_s = pins_s[16:15];
  assign rnw_s = pins_s[14];
  assign data_s = pins_s[13:6];
  assign mid_s = pins_s[5:0];

  // sampled stand-in for a transparent latch: follows while strobe high
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      emu_addr_lo <= 8'h00;
    end else if (strobe_s) begin
      emu_addr_lo <= data_s;
    end
  end

  // bus source: embedded processor or emulation pins
  always_comb begin
    if (emu) begin
      next_addr = {hi_s, mid_s, emu_addr_lo};
      next_wdata = data_s;
      next_rnw = rnw_s;
      next_valid = !strobe_s;
      next_phase = ephase_s && !strobe_s;
    end else begin
      next_addr = cpu_addr;
      next_wdata = cpu_wdata;
      next_rnw = cpu_rnw;
      next_valid = cpu_valid;
      next_phase = cpu_data_phase && cpu_valid;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bus_addr <= 16'h0000;
      bus_wdata <= 8'h00;
      bus_rnw <= 1'b1;
      bus_valid <= 1'b0;
      bus_data_phase <= 1'b0;
      bus_region <= 6'h00;
    end else begin
      bus_addr <= next_addr;
      bus_wdata <= next_wdata;
      bus_rnw <= next_rnw;
      bus_valid <= next_valid;
      bus_data_phase <= next_phase;
      bus_region <= next_valid ?
        decode(next_addr, boot_rom_select) : 6'h00;
    end
  end

  // control bits; set wins never arises as software is the only writer
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      boot_rom_select <= addr_decoder_pkg::BOOT_ROM_SEL_RESET;
      sleep_gate <= addr_decoder_pkg::SLEEP_GATE_RESET;
    end else begin
      if (boot_rom_wr) begin
        boot_rom_select <= boot_rom_wdata;
      end
      if (sleep_gate_wr) begin
        sleep_gate <= sleep_gate_wdata;
      end
    end
  end

  // bank register written from whichever master owns the bus
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bank_sel <= addr_decoder_pkg::BANK_SEL_RESET;
    end else if (bus_data_phase && !bus_rnw &&
                 bus_addr == addr_decoder_pkg::BANK_SEL_ADDR) begin
      bank_sel <= bus_wdata[4:0];
    end
  end

  // external select, decoded from the registered internal bus
  assign region = decode(bus_addr, boot_rom_select);
  assign banked = bus_addr[15:14] == addr_decoder_pkg::BANKED_TOP;
  assign ext_acc = bus_valid &&
    (region == addr_decoder_pkg::REGION_EXT ||
     region == addr_decoder_pkg::REGION_BANKED);
  assign sel_second = ext_acc && banked &&
    bank_sel[addr_decoder_pkg::BANK_CS_BIT];
  assign sel_program = ext_acc && !sel_second &&
    !(sleep_gate && bus_addr == addr_decoder_pkg::SLEEP_ADDR);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      program_mem_select_n <= 1'b1;
      second_mem_select_n <= 1'b1;
      out_enable_n <= 1'b1;
      write_enable_n <= 1'b1;
    end else begin
      program_mem_select_n <= !sel_program;
      second_mem_select_n <= !sel_second;
      // rnw picks one strobe, so both can never be low together
      out_enable_n <= !((sel_program || sel_second) &&
                        bus_data_phase && bus_rnw);
      write_enable_n <= !((sel_program || sel_second) &&
                          bus_data_phase && !bus_rnw);
    end
  end

  // page outputs, top address bits reach no pin directly
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      page_addr <= {addr_decoder_pkg::ROOT_PAGE_TOP, 2'h0};
    end else if (banked) begin
      page_addr <= bank_sel[3:0];
    end else begin
      page_addr <= {addr_decoder_pkg::ROOT_PAGE_TOP,
                    bus_addr[15:14]};
    end
  end

  // pin directions
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      addr_lo <= 8'h00;
      addr_mid_out <= 6'h00;
      addr_mid_oe <= 1'b0;
      rnw_out <= 1'b1;
      rnw_oe <= 1'b0;
      data_out <= 8'h00;
      data_oe <= 1'b0;
    end else begin
      addr_lo <= bus_addr[7:0];
      addr_mid_out <= bus_addr[13:8];
      addr_mid_oe <= !emu;
      rnw_out <= bus_rnw;
      rnw_oe <= !emu;
      data_out <= bus_wdata;
      // drive only on normal-mode external writes to avoid contention
      data_oe <= !emu && (sel_program || sel_second) &&
                 bus_data_phase && !bus_rnw;
    end
  end

  // read data returned to the embedded processor
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cpu_rdata <= 8'h00;
    end else if (!out_enable_n) begin
      cpu_rdata <= data_s;
    end
  end

endmodule : addr_decoder_bus_if

//--- tb/addr_decoder_bus_if_checker.sv
module addr_decoder_bus_if_checker (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // internal bus
  input wire logic [15:0] bus_addr,
  input wire logic bus_rnw,
  input wire logic bus_valid,
  input wire logic bus_data_phase,
  input wire logic [5:0] bus_region,
  // control and pins
  input wire logic sleep_gate,
  input wire logic [4:0] bank_sel,
  input wire logic bypass_cpu_pin,
  input wire logic rnw_oe,
  input wire logic data_oe,
  input wire logic addr_mid_oe,
  input wire logic [3:0] page_addr,
  input wire logic out_enable_n,
  input wire logic write_enable_n,
  input wire logic program_mem_select_n,
  input wire logic second_mem_select_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic banked;
  assign banked = bus_addr[15:14] == 2'h2;
  default clocking @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  a_strobe_excl: assert property (out_enable_n || write_enable_n)
    else $error("oe and we low together");
  a_one_select: assert property (
    program_mem_select_n || second_mem_select_n)
    else $error("both selects low");
  a_strobe_sel: assert property (!(out_enable_n && write_enable_n) |->
    !(program_mem_select_n && second_mem_select_n))
    else $error("strobe without select");
  a_root_page: assert property (!banked |=> second_mem_select_n &&
    page_addr == {2'h3, $past(bus_addr[15:14])})
    else $error("root page or select wrong");
  a_bank_page: assert property (banked |=>
    page_addr == $past(bank_sel[3:0]))
    else $error("banked page wrong");
  a_sleep_gate: assert property (sleep_gate && bus_valid &&
    bus_addr == 16'hffff |=> program_mem_select_n)
    else $error("program select during sleep");
  a_ext_read: assert property (bus_valid && bus_rnw &&
    bus_data_phase && bus_region == 6'h10 && !bus_addr[15] |=>
    !out_enable_n && !program_mem_select_n)
    else $error("external read strobes missing");
  a_int_quiet: assert property (bus_valid && bus_addr < 16'h1800 |=>
    &{program_mem_select_n, second_mem_select_n, out_enable_n,
    write_enable_n})
    else $error("external strobe on internal access");
  a_emu_pins: assert property (bypass_cpu_pin [*4] |=>
    !(rnw_oe || addr_mid_oe || data_oe))
    else $error("pins driven in emulation");
  a_norm_pins: assert property (!bypass_cpu_pin [*4] |=>
    rnw_oe && addr_mid_oe)
    else $error("pins not driven in normal mode");
endmodule : addr_decoder_bus_if_checker

bind addr_decoder_bus_if addr_decoder_bus_if_checker u_chk (.*);

//--- tb/ext_mem.sv
module ext_mem (
  // clock
  input wire logic clk,
  // memory pins
  input wire logic [7:0] addr_lo,
  input wire logic [7:0] data_out,
  input wire logic out_enable_n,
  input wire logic write_enable_n,
  input wire logic sel_n,
  output logic [7:0] mem_d
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [256];
  logic junk = 1'b0;
  always @(posedge clk) begin
    junk <= ~junk;
    if (!sel_n && !write_enable_n)
      mem[addr_lo] <= data_out;
  end
  // released pins toggle so a stale byte never looks valid
  assign mem_d = (!sel_n && !out_enable_n) ? mem[addr_lo] : {8{junk}};
endmodule : ext_mem

//--- tb/addr_decoder_bus_if_tb.sv
module addr_decoder_bus_if_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, sys_rst, cpu_rnw, cpu_valid, cpu_data_phase, boot_rom_wr;
  logic boot_rom_wdata, boot_rom_select, sleep_gate_wr, sleep_gate_wdata;
  logic sleep_gate, bus_rnw, bus_valid, bus_data_phase, bypass_cpu_pin;
  logic emu_addr_latch_strobe, emu_data_phase, emu_rnw, rnw_in, rnw_out;
  logic rnw_oe, data_oe, addr_mid_oe, out_enable_n, write_enable_n;
  logic program_mem_select_n, second_mem_select_n, oe_snap;
  logic [15:0] cpu_addr, bus_addr;
  logic [7:0] cpu_wdata, cpu_rdata, bus_wdata, data_in, data_out, addr_lo;
  logic [7:0] emu_d, mem_d, snap;
  logic [5:0] bus_region, addr_mid_in, addr_mid_out, emu_mid, reg_snap;
  logic [4:0] bank_sel;
  logic [3:0] page_addr;
  logic [1:0] emu_addr_hi;
  int miscompares, n_checks;
  localparam logic [15:0] MAP_A [7] = '{16'h0010, 16'h0050, 16'h1000,
    16'h2000, 16'h9000, 16'hc000, 16'hfe00};
  // {page, program sel, second sel, oe, we}
  localparam logic [7:0] MAP_E [7] = '{8'hcf, 8'hcf, 8'hcf, 8'hc5, 8'h05,
    8'hf5, 8'hff};
  // one-hot region code expected on the internal bus
  localparam logic [5:0] MAP_R [7] = '{6'h01, 6'h02, 6'h04, 6'h10, 6'h20,
    6'h10, 6'h08};
  assign rnw_in = rnw_oe ? rnw_out : emu_rnw;
  assign addr_mid_in = addr_mid_oe ? addr_mid_out : emu_mid;
  assign data_in = data_oe ? data_out : bypass_cpu_pin ? emu_d : mem_d;
  addr_decoder_bus_if dut (.*);
  ext_mem mem (.sel_n(program_mem_select_n & second_mem_select_n), .*);
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task results;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : results
  task acc(input logic [15:0] a, input logic rd, input logic [7:0] wd);
    @(negedge clk);
    cpu_addr = a;
    cpu_rnw = rd;
    cpu_wdata = wd;
    cpu_valid = 1'b1;
    cpu_data_phase = 1'b1;
    repeat (3) @(negedge clk);
    snap = {page_addr, program_mem_select_n, second_mem_select_n,
      out_enable_n, write_enable_n};
    reg_snap = bus_region;
    oe_snap = data_oe;
    repeat (3) @(negedge clk);
    cpu_valid = 1'b0;
    cpu_data_phase = 1'b0;
    @(negedge clk);
  endtask : acc
  task pulse(input logic sleep, input logic v);
    @(negedge clk);
    boot_rom_wr = !sleep;
    sleep_gate_wr = sleep;
    boot_rom_wdata = v;
    sleep_gate_wdata = v;
    @(negedge clk);
    boot_rom_wr = 1'b0;
    sleep_gate_wr = 1'b0;
  endtask : pulse
  task t_map;
    chk("boot_rom_select", 16'h1, boot_rom_select);
    chk("bank_sel", 16'h0, bank_sel);
    for (int i = 0; i < 7; i++) begin
      acc(MAP_A[i], 1'b1, 8'h00);
      chk("map", MAP_E[i], snap);
      chk("region", MAP_R[i], reg_snap);
    end
    $display("t_map done");
  endtask : t_map
  task t_bank;
    acc(16'h0030, 1'b0, 8'h15);
    chk("bank_sel", 16'h15, bank_sel);
    acc(16'h9000, 1'b1, 8'h00);
    chk("banked second", 16'h59, snap);
    acc(16'h4000, 1'b1, 8'h00);
    chk("root", 16'hd5, snap);
    acc(16'h0030, 1'b0, 8'h0a);
    acc(16'hbfff, 1'b1, 8'h00);
    chk("banked program", 16'ha5, snap);
    $display("t_bank done");
  endtask : t_bank
  task t_rw;
    acc(16'h2a5a, 1'b0, 8'h3c);
    chk("write strobes", 16'hc6, snap);
    chk("data_oe", 16'h1, oe_snap);
    chk("data_out", 16'h3c, data_out);
    chk("rnw_out", 16'h0, rnw_out);
    acc(16'h2a5a, 1'b1, 8'h00);
    chk("cpu_rdata", 16'h3c, cpu_rdata);
    chk("addr_lo", 16'h5a, addr_lo);
    chk("addr_mid_out", 16'h2a, addr_mid_out);
    chk("read data_oe", 16'h0, oe_snap);
    $display("t_rw done");
  endtask : t_rw
  task t_boot;
    pulse(1'b0, 1'b0);
    chk("boot_rom_select", 16'h0, boot_rom_select);
    acc(16'hfffe, 1'b1, 8'h00);
    chk("top external", 16'hf5, snap);
    chk("top region", 16'h10, reg_snap);
    pulse(1'b1, 1'b1);
    chk("sleep_gate", 16'h1, sleep_gate);
    acc(16'hffff, 1'b1, 8'h00);
    chk("sleep address", 16'hff, snap);
    acc(16'hfffe, 1'b1, 8'h00);
    chk("near sleep", 16'hf5, snap);
    $display("t_boot done");
  endtask : t_boot
  task t_emu;
    @(negedge clk);
    bypass_cpu_pin = 1'b1;
    emu_addr_hi = 2'h2;
    emu_mid = 6'h20;
    emu_d = 8'h34;
    emu_addr_latch_strobe = 1'b1;
    repeat (6) @(negedge clk);
    emu_addr_latch_strobe = 1'b0;
    emu_data_phase = 1'b1;
    emu_d = 8'hcb;
    repeat (6) @(negedge clk);
    chk("latched addr_lo", 16'h34, addr_lo);
    chk("pin enables", 16'h0, {rnw_oe, data_oe, addr_mid_oe});
    chk("emulated banked", 16'ha5, {page_addr, program_mem_select_n,
      second_mem_select_n, out_enable_n, write_enable_n});
    chk("emulated bus_addr", 16'ha034, bus_addr);
    // emulator writes the bank register through the pins
    emu_data_phase = 1'b0;
    emu_addr_latch_strobe = 1'b1;
    emu_addr_hi = 2'h0;
    emu_mid = 6'h00;
    emu_d = 8'h30;
    emu_rnw = 1'b0;
    repeat (6) @(negedge clk);
    emu_addr_latch_strobe = 1'b0;
    emu_data_phase = 1'b1;
    emu_d = 8'h1c;
    repeat (6) @(negedge clk);
    chk("emulated bank write", 16'h1c, bank_sel);
    emu_data_phase = 1'b0;
    emu_addr_latch_strobe = 1'b1;
    emu_rnw = 1'b1;
    bypass_cpu_pin = 1'b0;
    repeat (6) @(negedge clk);
    $display("t_emu done");
  endtask : t_emu
  initial begin
    {cpu_rnw, cpu_valid, cpu_data_phase, boot_rom_wr, boot_rom_wdata} = '0;
    {sleep_gate_wr, sleep_gate_wdata, bypass_cpu_pin, emu_data_phase} = '0;
    {emu_addr_latch_strobe, emu_rnw, emu_addr_hi, emu_mid, emu_d} = '0;
    cpu_addr = 16'h0000;
    cpu_wdata = 8'h00;
    emu_rnw = 1'b1;
    sys_rst = 1'b1;
    repeat (8) @(negedge clk);
    sys_rst = 1'b0;
    repeat (2) @(negedge clk);
    t_map();
    t_bank();
    t_rw();
    t_boot();
    t_emu();
    results();
  end
  initial begin
    #100000;
    miscompares++;
    results();
  end
endmodule : addr_decoder_bus_if_tb
